/* File: verilog/gps_regs.sv */
// Gigabit link status and indirect extended-register access bank
//
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/10ps
module gps_regs (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic [4:0]  reg_addr,
	input  wire logic [15:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [15:0] reg_rdata,
	input  wire logic        ms_fault_in,
	input  wire logic        ms_master_in,
	input  wire logic        loc_rcvr_ok_in,
	input  wire logic        rem_rcvr_ok_in,
	input  wire logic        partner_gig_full_duplex_able,
	input  wire logic        partner_gig_half_duplex_able,
	input  wire logic        symbol_tick,
	input  wire logic        idle_rx_send_n,
	input  wire logic        rx_error,
	output logic             irq
);
	import gps_pkg::*;

	// Status pins come from other domains: three-stage synchronisers
	logic [5:0] sync1_q;
	logic [5:0] sync2_q;
	logic [5:0] sync3_q;
	logic [5:0] stat_q;
	logic [5:0] stat_raw;
	assign stat_raw = {ms_fault_in, ms_master_in, loc_rcvr_ok_in, rem_rcvr_ok_in,
	                   partner_gig_full_duplex_able, partner_gig_half_duplex_able};
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sync1_q <= 6'h00;
			sync2_q <= 6'h00;
			sync3_q <= 6'h00;
		end else begin
			sync1_q <= stat_raw;
			sync2_q <= sync1_q;
			sync3_q <= sync2_q;
		end
	end

	// Filtered level changes only once stages two and three agree
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			stat_q <= 6'h00;
		end else begin
			for (int i = 0; i < 6; i++) begin
				if (sync2_q[i] == sync3_q[i]) begin
					stat_q[i] <= sync3_q[i];
				end
			end
		end
	end

	// Symbol-rate event inputs use the same on-chip clock, no synchroniser
	logic idle_err_ev;
	assign idle_err_ev = symbol_tick && idle_rx_send_n && rx_error;

	// Decode of this cycle's read strobe
	logic rd_status;
	logic rd_irq_status;
	assign rd_status     = reg_rd && (reg_addr == ADDR_GIG_LINK_STATUS);
	assign rd_irq_status = reg_rd && (reg_addr == ADDR_IRQ_STATUS);

	// Latched-high fault flag; a new fault during the clearing read wins
	logic ms_fault_q;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ms_fault_q <= 1'b0;
		end else if (stat_q[5]) begin
			ms_fault_q <= 1'b1;
		end else if (rd_status) begin
			ms_fault_q <= 1'b0;
		end
	end

	// Idle error counter saturates so a long error burst never wraps to small
	logic [7:0] idle_err_q;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			idle_err_q <= RST_IDLE_ERR;
		end else if (rd_status) begin
			idle_err_q <= idle_err_ev ? 8'h01 : RST_IDLE_ERR;
		end else if (idle_err_ev && idle_err_q != 8'hFF) begin
			idle_err_q <= idle_err_q + 8'h01;
		end
	end

	// Host-written registers: indirect control and write data
	logic [15:0] ctrl_q;
	logic [15:0] wdata_q;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_q  <= RST_CTRL;
			wdata_q <= RST_WDATA;
		end else if (reg_wr) begin
			if (reg_addr == ADDR_INDIRECT_CTRL) begin
				ctrl_q <= reg_wdata;
			end else if (reg_addr == ADDR_INDIRECT_WDATA) begin
				wdata_q <= reg_wdata;
			end
		end
	end

	// Extended register space, addressed by page and address fields
	logic [15:0] ext_mem [EXT_DEPTH];
	logic [8:0]  ext_idx;
	logic        ctrl_wr;
	assign ctrl_wr = reg_wr && (reg_addr == ADDR_INDIRECT_CTRL);
	assign ext_idx = {reg_wdata[POS_PAGE], reg_wdata[7:0]};

	// Access fires on the control write, so write data must already be loaded
	always_ff @(posedge clk) begin
		if (ctrl_wr && reg_wdata[POS_DIR_WRITE]) begin
			ext_mem[ext_idx] <= wdata_q;
		end
	end

	// Read result captured on a read-direction control write
	logic [15:0] rdata_ext_q;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_ext_q <= RST_RDATA;
		end else if (ctrl_wr && !reg_wdata[POS_DIR_WRITE]) begin
			rdata_ext_q <= ext_mem[ext_idx];
		end
	end

	// Interrupt status: sticky, write one to clear, set wins over clear
	logic [1:0] irq_stat_q;
	logic [1:0] irq_mask_q;
	logic [1:0] irq_ev;
	logic [1:0] irq_clr;
	assign irq_ev  = {idle_err_ev, stat_q[5] && !ms_fault_q};
	assign irq_clr = (reg_wr && reg_addr == ADDR_IRQ_STATUS) ? reg_wdata[1:0] : 2'h0;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_stat_q <= RST_IRQ;
		end else begin
			irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_ev;
		end
	end

	// Interrupt mask, one enables the matching status bit
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_mask_q <= RST_IRQ;
		end else if (reg_wr && reg_addr == ADDR_IRQ_MASK) begin
			irq_mask_q <= reg_wdata[1:0];
		end
	end

	// Registered level interrupt
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			irq <= 1'b0;
		end else begin
			irq <= |(((irq_stat_q & ~irq_clr) | irq_ev) & irq_mask_q);
		end
	end

	// Status word assembly; reserved bits read zero
	logic [15:0] status_word;
	assign status_word = {ms_fault_q | stat_q[5],
	                      stat_q[4],
	                      stat_q[3],
	                      stat_q[2],
	                      stat_q[1], stat_q[0],
	                      2'h0, idle_err_q};

	// Read data stands the cycle after the strobe only; unmapped reads zero
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= 16'h0000;
		end else if (!reg_rd) begin
			reg_rdata <= 16'h0000;
		end else if (reg_addr == ADDR_GIG_LINK_STATUS) begin
			reg_rdata <= status_word;
		end else if (reg_addr == ADDR_INDIRECT_CTRL) begin
			reg_rdata <= ctrl_q;
		end else if (reg_addr == ADDR_INDIRECT_WDATA) begin
			reg_rdata <= wdata_q;
		end else if (reg_addr == ADDR_INDIRECT_RDATA) begin
			reg_rdata <= rdata_ext_q;
		end else if (reg_addr == ADDR_EXT_ABILITY) begin
			reg_rdata <= EXT_ABILITY_VALUE;
		end else if (reg_addr == ADDR_IRQ_STATUS) begin
			reg_rdata <= {14'h0000, irq_stat_q};
		end else if (reg_addr == ADDR_IRQ_MASK) begin
			reg_rdata <= {14'h0000, irq_mask_q};
		end else begin
			reg_rdata <= 16'h0000;
		end
	end

	// Checks
	AST_FAULT_LATCH: assert property (@(posedge clk) disable iff (!rst_n)
		stat_q[5] |=> ms_fault_q) else $error("fault flag not latched");
	AST_FAULT_CLEAR: assert property (@(posedge clk) disable iff (!rst_n)
		(rd_status && !stat_q[5]) |=> !ms_fault_q) else $error("fault not cleared");
	AST_MASTER: assert property (@(posedge clk) disable iff (!rst_n)
		rd_status |=> reg_rdata[POS_MS_MASTER] == $past(stat_q[4]))
		else $error("resolution bit wrong");
	AST_LOC_RCVR: assert property (@(posedge clk) disable iff (!rst_n)
		rd_status |=> reg_rdata[POS_LOC_RCVR] == $past(stat_q[3]))
		else $error("local receiver bit wrong");
	AST_REM_RCVR: assert property (@(posedge clk) disable iff (!rst_n)
		rd_status |=> reg_rdata[POS_REM_RCVR] == $past(stat_q[2]))
		else $error("remote receiver bit wrong");
	AST_LP_ABLE: assert property (@(posedge clk) disable iff (!rst_n)
		rd_status |=> reg_rdata[POS_LP_FD:POS_LP_HD] == $past(stat_q[1:0]))
		else $error("partner ability wrong");
	AST_IDLE_CLR: assert property (@(posedge clk) disable iff (!rst_n)
		(rd_status && !idle_err_ev) |=> idle_err_q == 8'h00)
		else $error("idle count not cleared");
	AST_IDLE_INC: assert property (@(posedge clk) disable iff (!rst_n)
		(!rd_status && idle_err_ev && idle_err_q != 8'hFF) |=>
		idle_err_q == $past(idle_err_q) + 8'h01) else $error("idle count slip");
	AST_IDLE_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
		(!rd_status && !idle_err_ev) |=> $stable(idle_err_q))
		else $error("idle count moved");
	AST_CTRL_RB: assert property (@(posedge clk) disable iff (!rst_n)
		ctrl_wr ##1 (reg_rd && reg_addr == ADDR_INDIRECT_CTRL && !reg_wr) |=>
		reg_rdata == $past(reg_wdata, 2)) else $error("control readback");
	AST_EXT_RT: assert property (@(posedge clk) disable iff (!rst_n)
		(ctrl_wr && reg_wdata[POS_DIR_WRITE]) ##1
		(ctrl_wr && !reg_wdata[POS_DIR_WRITE] && ext_idx == $past(ext_idx)) |=>
		rdata_ext_q == $past(wdata_q, 2)) else $error("extended round trip");
	AST_EXT_ABIL: assert property (@(posedge clk) disable iff (!rst_n)
		(reg_rd && reg_addr == ADDR_EXT_ABILITY) |=> reg_rdata[15:12] == 4'h3)
		else $error("ability bits wrong");
	COV_FAULT: cover property (@(posedge clk) disable iff (!rst_n) stat_q[5] ##1 rd_status);
	COV_EXT_WR: cover property (@(posedge clk) disable iff (!rst_n)
		ctrl_wr && reg_wdata[POS_DIR_WRITE]);
	COV_EXT_RD: cover property (@(posedge clk) disable iff (!rst_n)
		ctrl_wr && !reg_wdata[POS_DIR_WRITE]);
	COV_IRQ: cover property (@(posedge clk) disable iff (!rst_n) $rose(irq));
	COV_IDLE_SAT: cover property (@(posedge clk) disable iff (!rst_n)
		idle_err_q == 8'hFF);

	// Read port: data only in the cycle after a strobe, zero otherwise
	AST_RDATA_IDLE: assert property (@(posedge clk) disable iff (!rst_n)
		!reg_rd |=> reg_rdata == 16'h0000)
		else $error("read data not zero outside a read");

	AST_RD_FAULT: assert property (@(posedge clk) disable iff (!rst_n)
		rd_status |=> reg_rdata[POS_MS_FAULT] == $past(ms_fault_q | stat_q[5]))
		else $error("fault bit read wrong");

	AST_RD_IDLE: assert property (@(posedge clk) disable iff (!rst_n)
		rd_status |=> reg_rdata[7:0] == $past(idle_err_q))
		else $error("idle count read wrong");

	AST_RD_RSVD: assert property (@(posedge clk) disable iff (!rst_n)
		rd_status |=> reg_rdata[9:8] == 2'h0)
		else $error("reserved status bits not zero");

	AST_RD_CTRL: assert property (@(posedge clk) disable iff (!rst_n)
		(reg_rd && reg_addr == ADDR_INDIRECT_CTRL) |=> reg_rdata == $past(ctrl_q))
		else $error("control read wrong");

	AST_RD_WDATA: assert property (@(posedge clk) disable iff (!rst_n)
		(reg_rd && reg_addr == ADDR_INDIRECT_WDATA) |=> reg_rdata == $past(wdata_q))
		else $error("write data read wrong");

	AST_RD_RDATA: assert property (@(posedge clk) disable iff (!rst_n)
		(reg_rd && reg_addr == ADDR_INDIRECT_RDATA) |=> reg_rdata == $past(rdata_ext_q))
		else $error("extended read data read wrong");

	// Ability word: no fibre modes, both copper gigabit modes
	AST_X_NONE: assert property (@(posedge clk) disable iff (!rst_n)
		(reg_rd && reg_addr == ADDR_EXT_ABILITY) |=> reg_rdata[15:14] == 2'h0)
		else $error("fibre ability bits set");

	AST_T_BOTH: assert property (@(posedge clk) disable iff (!rst_n)
		(reg_rd && reg_addr == ADDR_EXT_ABILITY) |=> reg_rdata[13:12] == 2'h3)
		else $error("copper ability bits clear");

	AST_IRQ_RB: assert property (@(posedge clk) disable iff (!rst_n)
		(reg_rd && reg_addr == ADDR_IRQ_STATUS) |=> reg_rdata[1:0] == $past(irq_stat_q))
		else $error("interrupt status read wrong");

	AST_MASK_RB: assert property (@(posedge clk) disable iff (!rst_n)
		(reg_rd && reg_addr == ADDR_IRQ_MASK) |=> reg_rdata[1:0] == $past(irq_mask_q))
		else $error("interrupt mask read wrong");

	// Fault latch holds until read and never sets by itself
	AST_FAULT_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
		(ms_fault_q && !rd_status) |=> ms_fault_q)
		else $error("fault latch dropped early");

	AST_FAULT_NOSET: assert property (@(posedge clk) disable iff (!rst_n)
		(!ms_fault_q && !stat_q[5]) |=> !ms_fault_q)
		else $error("fault latch set without fault");

	// Idle counter: saturation and clear racing an event
	AST_IDLE_SAT: assert property (@(posedge clk) disable iff (!rst_n)
		(idle_err_q == 8'hFF && !rd_status) |=> idle_err_q == 8'hFF)
		else $error("idle count wrapped");

	AST_IDLE_RD_EV: assert property (@(posedge clk) disable iff (!rst_n)
		(rd_status && idle_err_ev) |=> idle_err_q == 8'h01)
		else $error("event lost on clearing read");

	AST_IDLE_NOTICK: assert property (@(posedge clk) disable iff (!rst_n)
		(!symbol_tick && !rd_status) |=> $stable(idle_err_q))
		else $error("idle count moved without symbol");

	// Host-written registers take the strobed word and keep it otherwise
	AST_CTRL_WR: assert property (@(posedge clk) disable iff (!rst_n)
		ctrl_wr |=> ctrl_q == $past(reg_wdata))
		else $error("control not written");

	AST_CTRL_KEEP: assert property (@(posedge clk) disable iff (!rst_n)
		!ctrl_wr |=> $stable(ctrl_q))
		else $error("control changed without write");

	AST_WDATA_WR: assert property (@(posedge clk) disable iff (!rst_n)
		(reg_wr && reg_addr == ADDR_INDIRECT_WDATA) |=> wdata_q == $past(reg_wdata))
		else $error("write data not written");

	AST_WDATA_KEEP: assert property (@(posedge clk) disable iff (!rst_n)
		!(reg_wr && reg_addr == ADDR_INDIRECT_WDATA) |=> $stable(wdata_q))
		else $error("write data changed without write");

	AST_RDATA_KEEP: assert property (@(posedge clk) disable iff (!rst_n)
		!(ctrl_wr && !reg_wdata[POS_DIR_WRITE]) |=> $stable(rdata_ext_q))
		else $error("read data changed without read access");

	// Interrupt status, mask and level output
	AST_IRQ_SET_F: assert property (@(posedge clk) disable iff (!rst_n)
		irq_ev[IRQ_MS_FAULT] |=> irq_stat_q[IRQ_MS_FAULT])
		else $error("fault event not recorded");

	AST_IRQ_SET_I: assert property (@(posedge clk) disable iff (!rst_n)
		irq_ev[IRQ_IDLE_ERR] |=> irq_stat_q[IRQ_IDLE_ERR])
		else $error("idle error event not recorded");

	AST_IRQ_CLR: assert property (@(posedge clk) disable iff (!rst_n)
		(irq_clr[IRQ_MS_FAULT] && !irq_ev[IRQ_MS_FAULT]) |=> !irq_stat_q[IRQ_MS_FAULT])
		else $error("fault status not cleared");

	AST_IRQ_KEEP: assert property (@(posedge clk) disable iff (!rst_n)
		(irq_clr == 2'h0) |=> (irq_stat_q & $past(irq_stat_q)) == $past(irq_stat_q))
		else $error("interrupt status lost without clear");

	AST_MASK_WR: assert property (@(posedge clk) disable iff (!rst_n)
		(reg_wr && reg_addr == ADDR_IRQ_MASK) |=> irq_mask_q == $past(reg_wdata[1:0]))
		else $error("mask not written");

	AST_IRQ_LEVEL: assert property (@(posedge clk) disable iff (!rst_n)
		##1 irq == |(irq_stat_q & $past(irq_mask_q)))
		else $error("interrupt level wrong");

	// Filter: a bit moves only when stages two and three agree
	AST_SYNC_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
		(sync2_q[5] != sync3_q[5]) |=> stat_q[5] == $past(stat_q[5]))
		else $error("filtered fault moved on disagreement");

	AST_SYNC_AGREE: assert property (@(posedge clk) disable iff (!rst_n)
		(sync2_q == sync3_q) |=> stat_q == $past(sync3_q))
		else $error("filtered status missed agreement");
endmodule : gps_regs

/* File: verilog/gps_pkg.sv */
// Constants for the gigabit status and indirect extended-register block
package gps_pkg;
	// Register addresses on the management port
	localparam logic [4:0]  ADDR_GIG_LINK_STATUS   = 5'h0A;
	localparam logic [4:0]  ADDR_INDIRECT_CTRL     = 5'h0B;
	localparam logic [4:0]  ADDR_INDIRECT_WDATA    = 5'h0C;
	localparam logic [4:0]  ADDR_INDIRECT_RDATA    = 5'h0D;
	localparam logic [4:0]  ADDR_EXT_ABILITY       = 5'h0F;
	localparam logic [4:0]  ADDR_IRQ_STATUS        = 5'h18;
	localparam logic [4:0]  ADDR_IRQ_MASK          = 5'h19;
	// Gigabit link status field positions
	localparam int          POS_MS_FAULT           = 15;
	localparam int          POS_MS_MASTER          = 14;
	localparam int          POS_LOC_RCVR           = 13;
	localparam int          POS_REM_RCVR           = 12;
	localparam int          POS_LP_FD              = 11;
	localparam int          POS_LP_HD              = 10;
	// Indirect control field positions
	localparam int          POS_DIR_WRITE          = 15;
	localparam int          POS_PAGE               = 8;
	// Extended ability status constant value (1000X none, 1000T both)
	localparam logic [15:0] EXT_ABILITY_VALUE      = 16'h3000;
	// Reset values
	localparam logic [15:0] RST_CTRL               = 16'h0000;
	localparam logic [15:0] RST_WDATA              = 16'h0000;
	localparam logic [15:0] RST_RDATA              = 16'h0000;
	localparam logic [7:0]  RST_IDLE_ERR           = 8'h00;
	localparam logic [1:0]  RST_IRQ                = 2'h0;
	// Interrupt status bits
	localparam int          IRQ_MS_FAULT           = 0;
	localparam int          IRQ_IDLE_ERR           = 1;
	// Extended register space size
	localparam int          EXT_DEPTH              = 512;
endpackage : gps_pkg

/* File: dv/gps_host_model.sv */
// Management host model that speaks the register port
`timescale 1ns/10ps
module gps_host_model (
	input  wire logic        clk,
	output logic      [4:0]  reg_addr,
	output logic      [15:0] reg_wdata,
	output logic             reg_wr,
	output logic             reg_rd,
	input  wire logic [15:0] reg_rdata
);
	// Idle port at time zero
	initial begin
		reg_addr = 5'h00;
		reg_wdata = 16'h0000;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	end
	// One-cycle write; inverted values on release so stale data never looks valid
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		reg_addr <= ~a;
		reg_wdata <= ~d;
	endtask : wr
	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [4:0] a, output logic [15:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		reg_addr <= ~a;
		#1;
		d = reg_rdata;
	endtask : rd
endmodule : gps_host_model

/* File: dv/gps_regs_tb.sv */
// Self-checking bench for the gigabit status and indirect register bank
`timescale 1ns/10ps
module gps_regs_tb;
	import gps_pkg::*;
	logic        clk, rst_n, reg_wr, reg_rd, irq, fault, tick_q, idle, rx_err;
	logic [4:0]  reg_addr, st;
	logic [15:0] reg_wdata, reg_rdata, v;
	int          n_fail, n_compared, cyc;

	gps_regs DUT (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ms_fault_in(fault),
		.ms_master_in(st[4]), .loc_rcvr_ok_in(st[3]), .rem_rcvr_ok_in(st[2]),
		.partner_gig_full_duplex_able(st[1]), .partner_gig_half_duplex_able(st[0]),
		.symbol_tick(tick_q), .idle_rx_send_n(idle), .rx_error(rx_err), .irq(irq));
	gps_host_model host (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

	// 20 MHz clock
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	task automatic give_verdict();
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : give_verdict
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		n_compared++;
		if (g !== e) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic rchk(input logic [4:0] a, input logic [15:0] e, input string nm);
		host.rd(a, v);
		chk(nm, e, v);
	endtask : rchk
	// Symbol pulses with a gap, as the receive path would give them
	task automatic tick(input int n);
		repeat (n) begin
			@(posedge clk);
			tick_q <= 1'b1;
			@(posedge clk);
			tick_q <= 1'b0;
		end
	endtask : tick
	// Ceiling far above the 660 or so cycles the sequence needs
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_fail++;
			give_verdict();
		end
	end
	// Main sequence
	initial begin
		{rst_n, fault, tick_q, idle, rx_err, st, n_fail, n_compared, cyc} = '0;
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		rchk(ADDR_GIG_LINK_STATUS, 16'h0000, "status_rst");
		rchk(ADDR_INDIRECT_CTRL, 16'h0000, "ctrl_rst");
		rchk(ADDR_INDIRECT_WDATA, 16'h0000, "wdata_rst");
		rchk(ADDR_INDIRECT_RDATA, 16'h0000, "rdata_rst");
		rchk(ADDR_EXT_ABILITY, 16'h3000, "ext_ability");
		rchk(5'h1F, 16'h0000, "unmapped");
		// Async inputs need four edges, so wait six before reading
		for (int i = 0; i < 5; i++) begin
			st <= 5'h01 << i;
			repeat (6) @(posedge clk);
			rchk(ADDR_GIG_LINK_STATUS, 16'h0400 << i, "mirror");
		end
		st <= 5'h00;
		fault <= 1'b1;
		repeat (8) @(posedge clk);
		fault <= 1'b0;
		repeat (8) @(posedge clk);
		rchk(ADDR_GIG_LINK_STATUS, 16'h8000, "fault_latched");
		rchk(ADDR_GIG_LINK_STATUS, 16'h0000, "fault_cleared");
		rchk(ADDR_IRQ_STATUS, 16'h0001, "irq_fault");
		chk("irq_masked", 16'h0000, {15'h0000, irq});
		host.wr(ADDR_IRQ_MASK, 16'h0003);
		repeat (2) @(posedge clk);
		#1 chk("irq_on", 16'h0001, {15'h0000, irq});
		host.wr(ADDR_IRQ_STATUS, 16'h0001);
		repeat (2) @(posedge clk);
		#1 chk("irq_off", 16'h0000, {15'h0000, irq});
		// Only ticks with both idle reception and error may count
		idle <= 1'b1;
		rx_err <= 1'b1;
		tick(3);
		rx_err <= 1'b0;
		tick(1);
		rx_err <= 1'b1;
		idle <= 1'b0;
		tick(1);
		idle <= 1'b1;
		rchk(ADDR_GIG_LINK_STATUS, 16'h0003, "idle_count");
		rchk(ADDR_GIG_LINK_STATUS, 16'h0000, "idle_cleared");
		rchk(ADDR_IRQ_STATUS, 16'h0002, "irq_idle");
		tick(260);
		rx_err <= 1'b0;
		rchk(ADDR_GIG_LINK_STATUS, 16'h00FF, "idle_sat");
		host.wr(ADDR_IRQ_STATUS, 16'h0003);
		rchk(ADDR_IRQ_STATUS, 16'h0000, "irq_cleared");
		// Same address on both pages tells the page bit apart
		host.wr(ADDR_INDIRECT_WDATA, 16'hA5C3);
		host.wr(ADDR_INDIRECT_CTRL, 16'h8137);
		host.wr(ADDR_INDIRECT_WDATA, 16'h1E2D);
		host.wr(ADDR_INDIRECT_CTRL, 16'h8037);
		host.wr(ADDR_INDIRECT_CTRL, 16'h0137);
		rchk(ADDR_INDIRECT_RDATA, 16'hA5C3, "ext_page1");
		host.wr(ADDR_INDIRECT_CTRL, 16'h0037);
		rchk(ADDR_INDIRECT_RDATA, 16'h1E2D, "ext_page0");
		rchk(ADDR_INDIRECT_CTRL, 16'h0037, "ctrl_back");
		rchk(ADDR_INDIRECT_WDATA, 16'h1E2D, "wdata_back");
		host.wr(ADDR_INDIRECT_RDATA, 16'hFFFF);
		host.wr(ADDR_EXT_ABILITY, 16'h0000);
		rchk(ADDR_INDIRECT_RDATA, 16'h1E2D, "rdata_ro");
		rchk(ADDR_EXT_ABILITY, 16'h3000, "ext_ro");
		give_verdict();
	end
endmodule : gps_regs_tb
